// ===== common/synth_port_cfg.svh
`ifndef SYNTH_PORT_CFG_SVH
`define SYNTH_PORT_CFG_SVH
`define WORD_BITS        24
`define SEL_INT_FRAC     2'h0
`define SEL_REF_DIV      2'h1
`define SEL_CONTROL      2'h2
`define SEL_NOISE_SPUR   2'h3
`define FAST_LOCK_POS    23
`define WHOLE_HI         22
`define WHOLE_LO         14
`define NUMER_HI         13
`define NUMER_LO         2
`define MUX_SEL_HI       22
`define MUX_SEL_LO       20
`define REF_DIV_HI       17
`define REF_DIV_LO       14
`define DENOM_HI         13
`define DENOM_LO         2
`define DOUBLER_POS      2
`define WHOLE_MIN        9'h01f
`define WHOLE_MAX        9'h1ff
`define DENOM_MIN        12'h002
`define REF_DIV_MIN      4'h1
`define REF_DIV_MAX      4'hf
`define ADDR_CMD_WORD    32'h0000_0000
`define ADDR_CMD_GO      32'h0000_0004
`define ADDR_STATUS      32'h0000_0008
`define ADDR_DENOM       32'h0000_000c
`define ADDR_WHOLE       32'h0000_0010
`define ADDR_MUX         32'h0000_0014
`define SCLK_DIV         8'h04
`endif

// ===== common/synth_port_pkg.sv
package synth_port_pkg;
   typedef enum logic [1:0] {
      latch_int_frac,
      latch_ref_div,
      latch_control,
      latch_noise_spur
   } latch_sel_t;
   typedef enum logic [2:0] {
      mux_tristate,
      mux_dvdd,
      mux_dgnd,
      mux_ref_scaled,
      mux_rf_scaled,
      mux_lock_detect,
      mux_lock_alt,
      mux_reserved
   } mux_sel_t;
   typedef enum {
      host_idle,
      host_shift_low,
      host_shift_high,
      host_load_high,
      host_load_low
   } host_state_t;
endpackage

// ===== common/synth_link_if.sv
`timescale 1ns/1ps
interface synth_link_if;
   logic serial_clock;
   logic serial_data;
   logic load_strobe;
   logic test_mux_output;
   modport device (
      input  serial_clock,
      input  serial_data,
      input  load_strobe,
      output test_mux_output
   );
   modport host (
      output serial_clock,
      output serial_data,
      output load_strobe,
      input  test_mux_output
   );
endinterface

// ===== rtl/synth_port_latches.sv
`timescale 1ns/1ps
`include "synth_port_cfg.svh"
module synth_port_latches (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  load_pulse,
   input  wire logic [`WORD_BITS-1:0] word,
   output logic      [`WORD_BITS-1:0] int_frac_latch,
   output logic      [`WORD_BITS-1:0] ref_div_latch,
   output logic      [`WORD_BITS-1:0] control_latch,
   output logic      [`WORD_BITS-1:0] noise_spur_latch,
   output logic      [11:0]           active_denominator
);
   import synth_port_pkg::*;

   logic [`WORD_BITS-1:0] latch [4];
   logic [`WORD_BITS-1:0] next_latch [4];
   logic [11:0]           next_active_denominator;
   logic [1:0]            sel;

   // ==========================================================
   // Latch steering
   always_comb begin
      sel = word[1:0];
      next_active_denominator = active_denominator;
      for (int i = 0; i < 4; i++) begin
         next_latch[i] = latch[i];
      end
      if (load_pulse) begin
         next_latch[sel] = word;
         if (sel == `SEL_INT_FRAC) begin
            next_active_denominator = latch[`SEL_REF_DIV][`DENOM_HI:`DENOM_LO];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            latch[i] <= '0;
         end
         active_denominator <= 12'h002;
      end else begin
         for (int i = 0; i < 4; i++) begin
            latch[i] <= next_latch[i];
         end
         active_denominator <= next_active_denominator;
      end
   end

   assign int_frac_latch   = latch[`SEL_INT_FRAC];
   assign ref_div_latch    = latch[`SEL_REF_DIV];
   assign control_latch    = latch[`SEL_CONTROL];
   assign noise_spur_latch = latch[`SEL_NOISE_SPUR];
endmodule

// ===== rtl/synth_port_device.sv
`timescale 1ns/1ps
`include "synth_port_cfg.svh"
// How it works
// - shift data MSB first on clock rise
// - load strobe rise fills one latch
// - two low bits select latch
// - 00 int, 01 ref, 10 ctl, 11 noise
// - new denominator used after int write
// - host writes int after denominator
// - whole value 31 to 511
// - reference divider 1 to 15, doubler
// - denominator 2 to 4095
// - numerator below denominator
// - ratio is whole plus fraction
// - hold ref, whole, numerator, denominator
// - fast lock 23, whole 22:14, numerator 13:2
// - three bits pick mux output
// - lock detect high with low glitches
// - strobe high loads chosen latch
module synth_port_device (
   input  wire logic       pclk,
   input  wire logic       presetn,
   synth_link_if.device    link,
   input  wire logic       ref_tick,
   input  wire logic       rf_tick,
   input  wire logic       lock_in,
   output logic            fast_lock_bit,
   output logic [8:0]      whole_value,
   output logic [11:0]     numerator,
   output logic [11:0]     partial_denominator,
   output logic [3:0]      ref_divide,
   output logic            doubler,
   output logic            config_error
);
   import synth_port_pkg::*;

   logic [`WORD_BITS-1:0] shreg;
   logic [`WORD_BITS-1:0] next_shreg;
   logic                  sclk_q;
   logic                  load_q;
   logic                  load_pulse;
   logic [`WORD_BITS-1:0] int_frac_latch;
   logic [`WORD_BITS-1:0] ref_div_latch;
   logic [`WORD_BITS-1:0] control_latch;
   logic [`WORD_BITS-1:0] noise_spur_latch;
   logic [11:0]           active_den;
   logic [3:0]            ref_count;
   logic [3:0]            next_ref_count;
   logic                  ref_scaled;
   logic                  next_ref_scaled;
   logic                  rf_scaled;
   logic                  next_rf_scaled;
   logic                  mux_out;
   logic                  next_mux_out;
   logic                  next_error;
   mux_sel_t              mux_sel;

   // ==========================================================
   // Serial shift path
   always_comb begin
      next_shreg = shreg;
      if (link.serial_clock && !sclk_q) begin
         next_shreg = {shreg[`WORD_BITS-2:0], link.serial_data};
      end
   end

   assign load_pulse = link.load_strobe && !load_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shreg  <= '0;
         sclk_q <= 1'b0;
         load_q <= 1'b0;
      end else begin
         shreg  <= next_shreg;
         sclk_q <= link.serial_clock;
         load_q <= link.load_strobe;
      end
   end

   synth_port_latches u_latches (
      .pclk               (pclk),
      .presetn            (presetn),
      .load_pulse         (load_pulse),
      .word               (shreg),
      .int_frac_latch     (int_frac_latch),
      .ref_div_latch      (ref_div_latch),
      .control_latch      (control_latch),
      .noise_spur_latch   (noise_spur_latch),
      .active_denominator (active_den)
   );

   // ==========================================================
   // Dividers, mux and range check
   always_comb begin
      next_ref_count  = ref_count;
      next_ref_scaled = ref_scaled;
      next_rf_scaled  = rf_scaled;
      if (ref_tick) begin
         if (ref_count + 4'h1 >= ref_div_latch[`REF_DIV_HI:`REF_DIV_LO]) begin
            next_ref_count  = 4'h0;
            next_ref_scaled = !ref_scaled;
         end else begin
            next_ref_count = ref_count + 4'h1;
         end
      end
      if (rf_tick) begin
         next_rf_scaled = !rf_scaled;
      end
      mux_sel = mux_sel_t'(ref_div_latch[`MUX_SEL_HI:`MUX_SEL_LO]);
      case (mux_sel)
         mux_dvdd:        next_mux_out = 1'b1;
         mux_ref_scaled:  next_mux_out = ref_scaled;
         mux_rf_scaled:   next_mux_out = rf_scaled;
         mux_lock_detect: next_mux_out = lock_in;
         mux_lock_alt:    next_mux_out = lock_in;
         default:         next_mux_out = 1'b0;
      endcase
      next_error = (int_frac_latch[`WHOLE_HI:`WHOLE_LO] < `WHOLE_MIN)
                || (active_den < `DENOM_MIN)
                || (int_frac_latch[`NUMER_HI:`NUMER_LO] >= active_den)
                || (ref_div_latch[`REF_DIV_HI:`REF_DIV_LO] < `REF_DIV_MIN);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_count           <= 4'h0;
         ref_scaled          <= 1'b0;
         rf_scaled           <= 1'b0;
         mux_out             <= 1'b0;
         config_error        <= 1'b0;
         fast_lock_bit       <= 1'b0;
         whole_value         <= 9'h000;
         numerator           <= 12'h000;
         partial_denominator <= 12'h002;
         ref_divide          <= 4'h0;
         doubler             <= 1'b0;
      end else begin
         ref_count    <= next_ref_count;
         ref_scaled   <= next_ref_scaled;
         rf_scaled    <= next_rf_scaled;
         mux_out      <= next_mux_out;
         config_error <= next_error;
         fast_lock_bit <= int_frac_latch[`FAST_LOCK_POS];
         whole_value   <= int_frac_latch[`WHOLE_HI:`WHOLE_LO];
         numerator     <= int_frac_latch[`NUMER_HI:`NUMER_LO];
         partial_denominator <= active_den;
         ref_divide          <= ref_div_latch[`REF_DIV_HI:`REF_DIV_LO];
         doubler             <= control_latch[`DOUBLER_POS];
      end
   end

   assign link.test_mux_output = mux_out;
endmodule

// ===== rtl/synth_port_host.sv
`timescale 1ns/1ps
`include "synth_port_cfg.svh"
module synth_port_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   synth_link_if.host       link
);
   import synth_port_pkg::*;

   host_state_t           state;
   host_state_t           next_state;
   logic [`WORD_BITS-1:0] word;
   logic [`WORD_BITS-1:0] next_word;
   logic [4:0]            bits;
   logic [4:0]            next_bits;
   logic [7:0]            div;
   logic [7:0]            next_div;
   logic                  tick;
   logic                  sclk;
   logic                  next_sclk;
   logic                  sdata;
   logic                  next_sdata;
   logic                  le;
   logic                  next_le;
   logic                  mux_q;
   logic [31:0]           next_prdata;
   logic                  next_pready;
   logic                  next_pslverr;
   logic                  busy;
   logic                  go;

   assign tick = (div == `SCLK_DIV - 8'h01);
   assign busy = (state != host_idle);

   // ==========================================================
   // APB slave: word, go, status
   always_comb begin
      next_prdata  = 32'h0000_0000;
      next_pready  = 1'b0;
      next_pslverr = 1'b0;
      go           = 1'b0;
      if (psel && !penable) begin
         next_pready = 1'b1;
      end
      if (psel && penable && pready) begin
         next_pready = 1'b0;
      end
      if (psel && !penable) begin
         if (paddr == `ADDR_CMD_WORD) begin
            next_prdata = {8'h00, word};
         end else if (paddr == `ADDR_CMD_GO) begin
            next_pslverr = !pwrite && 1'b0;
         end else if (paddr == `ADDR_STATUS) begin
            next_prdata = {30'h0, mux_q, busy};
         end else begin
            next_pslverr = 1'b1;
         end
      end
      if (psel && penable && pready && pwrite && !pslverr && paddr == `ADDR_CMD_GO && !busy) begin
         go = 1'b1;
      end
   end

   // ==========================================================
   // Serial sequencer
   always_comb begin
      next_state = state;
      next_word  = word;
      next_bits  = bits;
      next_div   = tick ? 8'h00 : div + 8'h01;
      next_sclk  = sclk;
      next_sdata = sdata;
      next_le    = le;
      if (psel && penable && pready && pwrite && paddr == `ADDR_CMD_WORD && !busy) begin
         next_word = pwdata[`WORD_BITS-1:0];
      end
      case (state)
         host_idle: begin
            if (go) begin
               next_state = host_shift_low;
               next_bits  = 5'd0;
               next_div   = 8'h00;
               next_sdata = word[`WORD_BITS-1];
            end
         end
         host_shift_low: begin
            if (tick) begin
               next_sclk  = 1'b1;
               next_state = host_shift_high;
            end
         end
         host_shift_high: begin
            if (tick) begin
               next_sclk = 1'b0;
               if (bits == 5'd23) begin
                  next_state = host_load_high;
               end else begin
                  next_bits  = bits + 5'd1;
                  next_sdata = word[5'd22 - bits];
                  next_state = host_shift_low;
               end
            end
         end
         host_load_high: begin
            if (tick) begin
               next_le    = 1'b1;
               next_state = host_load_low;
            end
         end
         host_load_low: begin
            if (tick) begin
               next_le    = 1'b0;
               next_state = host_idle;
            end
         end
         default: next_state = host_idle;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= host_idle;
         word    <= '0;
         bits    <= 5'd0;
         div     <= 8'h00;
         sclk    <= 1'b0;
         sdata   <= 1'b0;
         le      <= 1'b0;
         mux_q   <= 1'b0;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         state   <= next_state;
         word    <= next_word;
         bits    <= next_bits;
         div     <= next_div;
         sclk    <= next_sclk;
         sdata   <= next_sdata;
         le      <= next_le;
         mux_q   <= link.test_mux_output;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   assign link.serial_clock = sclk;
   assign link.serial_data  = sdata;
   assign link.load_strobe  = le;
endmodule

// ===== test/synth_serial_program_port_checker.sv
`timescale 1ns/1ps
// ==========================================
// Link checker
module synth_serial_program_port_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic serial_clock,
   input wire logic serial_data,
   input wire logic load_strobe,
   input wire logic test_mux_output
);
   logic       prev_sc;
   logic [4:0] bit_count;
   logic [4:0] next_bit_count;

   // Counts clock rises per frame; the strobe itself clears it.
   always_comb begin
      next_bit_count = bit_count;
      if (load_strobe) begin
         next_bit_count = 5'h00;
      end else if (serial_clock && !prev_sc) begin
         next_bit_count = bit_count + 5'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_sc   <= 1'b0;
         bit_count <= 5'h00;
      end else begin
         prev_sc   <= serial_clock;
         bit_count <= next_bit_count;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_strobe_apart;
      serial_clock |-> !load_strobe;
   endproperty
   a_strobe_apart: assert property (p_strobe_apart) else $error("strobe high with clock high");
   property p_data_hold;
      $rose(serial_clock) |-> $stable(serial_data) [*4];
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");
   property p_clk_high;
      $rose(serial_clock) |-> serial_clock [*4] ##1 !serial_clock;
   endproperty
   a_clk_high: assert property (p_clk_high) else $error("clock high time wrong");
   property p_clk_low;
      $fell(serial_clock) |-> !serial_clock [*4];
   endproperty
   a_clk_low: assert property (p_clk_low) else $error("clock low time short");
   property p_strobe_len;
      $rose(load_strobe) |-> load_strobe [*4] ##1 !load_strobe;
   endproperty
   a_strobe_len: assert property (p_strobe_len) else $error("strobe width wrong");
   property p_bit_count;
      $rose(load_strobe) |-> bit_count == 5'h18;
   endproperty
   a_bit_count: assert property (p_bit_count) else $error("frame not 24 bits");
   property p_after_strobe;
      $fell(load_strobe) |-> !serial_clock [*2];
   endproperty
   a_after_strobe: assert property (p_after_strobe) else $error("clock right after strobe");
   property p_idle_reset;
      $rose(presetn) |-> !serial_clock && !load_strobe;
   endproperty
   a_idle_reset: assert property (p_idle_reset) else $error("link not idle after reset");

   c_load: cover property ($rose(load_strobe));
   c_one: cover property ($rose(serial_clock) && serial_data);
   c_mux: cover property ($rose(test_mux_output));
endmodule

// ===== test/tb_synth_serial_program_port.sv
`timescale 1ns/1ps
`include "synth_port_cfg.svh"
module tb_synth_serial_program_port;
   import synth_port_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, rd, seed, tseed;
   logic        ref_tick, rf_tick, lock_in, fast_lock_bit, doubler, config_error;
   logic        e_fl, e_dbl, prev_sc, prev_ls, err, e_rf, e_rf_q, e_rs, e_rs_q;
   logic [4:0]  e_rcnt;
   logic [8:0]  whole_value, e_whole, w;
   logic [11:0] numerator, partial_denominator, e_num, e_den, e_pend, n, d;
   logic [3:0]  ref_divide, e_ref, r, r_live;
   logic [2:0]  e_mux;
   logic [23:0] sent, mon_word, word;
   int          n_errors, n_compared;

   synth_link_if link_bus ();
   synth_port_host u_synth_port_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link_bus));
   synth_port_device u_synth_port_device (.pclk(pclk), .presetn(presetn), .link(link_bus),
      .ref_tick(ref_tick), .rf_tick(rf_tick), .lock_in(lock_in), .fast_lock_bit(fast_lock_bit),
      .whole_value(whole_value), .numerator(numerator), .partial_denominator(partial_denominator),
      .ref_divide(ref_divide), .doubler(doubler), .config_error(config_error));
   synth_serial_program_port_checker u_checker (.pclk(pclk), .presetn(presetn),
      .serial_clock(link_bus.serial_clock), .serial_data(link_bus.serial_data),
      .load_strobe(link_bus.load_strobe), .test_mux_output(link_bus.test_mux_output));

   always #20 pclk = ~pclk;

   // ==========================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   function automatic logic [23:0] ref_word(input logic [2:0] m, input logic [3:0] rr, input logic [11:0] dd);
      return {1'b0, m, 2'b00, rr, dd, `SEL_REF_DIV};
   endfunction

   function automatic logic exp_err();
      return (e_whole < `WHOLE_MIN) || (e_den < `DENOM_MIN) || (e_num >= e_den) || (e_ref == 4'h0);
   endfunction

   function automatic logic exp_mux();
      case (mux_sel_t'(e_mux))
         mux_dvdd: return 1'b1;
         mux_ref_scaled: return e_rs_q;
         mux_rf_scaled: return e_rf_q;
         mux_lock_detect, mux_lock_alt: return lock_in;
         default: return 1'b0;
      endcase
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] dat);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         n_errors++;
         $display("unexpected at %0t: no pready", $time);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // The expectations follow each latch as the word commits.
   task automatic send(input logic [23:0] wd);
      int k;
      sent = wd;
      apb(1'b1, `ADDR_CMD_WORD, {8'h00, wd});
      apb(1'b0, `ADDR_CMD_WORD, 32'h0000_0000);
      chk(rd, {8'h00, wd}, "word readback");
      apb(1'b1, `ADDR_CMD_GO, 32'h0000_0001);
      k = 0;
      do begin
         apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
         k++;
      end while (rd[0] !== 1'b0 && k < 200);
      chk({31'h0, rd[0]}, 32'h0, "busy stuck");
      repeat (4) @(posedge pclk);
      case (wd[1:0])
         `SEL_INT_FRAC: {e_fl, e_whole, e_num, e_den} = {wd[23:2], e_pend};
         `SEL_REF_DIV: {e_mux, e_ref, e_pend} = {wd[22:20], wd[17:14], wd[13:2]};
         `SEL_CONTROL: e_dbl = wd[`DOUBLER_POS];
         default: ;
      endcase
   endtask

   task automatic check_all();
      chk(32'(fast_lock_bit), 32'(e_fl), "fast lock");
      chk(32'(whole_value), 32'(e_whole), "whole");
      chk(32'(numerator), 32'(e_num), "numerator");
      chk(32'(partial_denominator), 32'(e_den), "denominator");
      chk(32'(ref_divide), 32'(e_ref), "ref divide");
      chk(32'(doubler), 32'(e_dbl), "doubler");
      chk(32'(config_error), 32'(exp_err()), "config error");
      chk(32'(link_bus.test_mux_output), 32'(exp_mux()), "mux");
   endtask

   // ==========================================
   // Wire monitor and free-running inputs
   always @(posedge pclk) begin
      prev_sc <= link_bus.serial_clock;
      prev_ls <= link_bus.load_strobe;
      tseed   <= xs(tseed);
      ref_tick <= tseed[3];
      rf_tick  <= tseed[9];
      if (link_bus.serial_clock && !prev_sc) mon_word <= {mon_word[22:0], link_bus.serial_data};
      if (link_bus.load_strobe && !prev_ls) chk({8'h00, mon_word}, {8'h00, sent}, "wire word");
      // Scaled outputs are modelled here; the reference ratio follows the word committed by the strobe.
      if (!presetn) begin
         {e_rf, e_rf_q, e_rs, e_rs_q, e_rcnt, r_live} <= '0;
      end else begin
         e_rf   <= e_rf ^ rf_tick;
         e_rf_q <= e_rf;
         e_rs_q <= e_rs;
         if (ref_tick && (e_rcnt + 5'h01 >= {1'b0, r_live})) begin
            e_rcnt <= 5'h00;
            e_rs   <= !e_rs;
         end else if (ref_tick) begin
            e_rcnt <= e_rcnt + 5'h01;
         end
         if (link_bus.load_strobe && !prev_ls && sent[1:0] == `SEL_REF_DIV) r_live <= sent[17:14];
      end
   end

   initial begin
      repeat (40000) @(posedge pclk);
      n_errors++;
      give_verdict();
   end

   // ==========================================
   // Main sequence
   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {ref_tick, rf_tick, lock_in, prev_sc, prev_ls, mon_word, sent} = '0;
      {e_fl, e_dbl, e_whole, e_num, e_pend, e_ref, e_mux} = '0;
      e_den = `DENOM_MIN;
      seed = 32'hefbc41e9;
      tseed = 32'hefbc41e9;
      repeat (3) @(posedge pclk);
      chk({10'h0, fast_lock_bit, whole_value, numerator}, 32'h0, "reset a");
      chk({20'h0, partial_denominator}, {20'h0, `DENOM_MIN}, "reset d");
      chk({25'h0, ref_divide, doubler, config_error, link_bus.test_mux_output}, 32'h0, "reset b");
      presetn <= 1'b1;
      apb(1'b0, 32'h0000_0040, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped");
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         {w, n, d, r} = {seed[8:0], seed[20:9], seed[31:20], seed[12:9]};
         case (i)
            0: {w, n, d, r} = {9'h01f, 12'h000, 12'h002, 4'h1};
            1: {w, n, d, r} = {9'h1ff, 12'hffe, 12'hfff, 4'hf};
            2: {w, n, d, r} = {9'h01e, 12'h000, 12'h002, 4'h1};
            3: {w, n, d, r} = {9'h01f, 12'h002, 12'h002, 4'h1};
            4: {w, n, d, r} = {9'h064, 12'h001, 12'h001, 4'h5};
            5: {w, n, d, r} = {9'h064, 12'h000, 12'h005, 4'h0};
            default: ;
         endcase
         send(ref_word(3'h1, r, d));
         check_all();
         send({seed[31], w, n, `SEL_INT_FRAC});
         check_all();
      end
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         word = {seed[23:2], 2'(i)};
         if (word[1:0] == `SEL_REF_DIV) word[22:20] = 3'h1;
         send(word);
         check_all();
      end
      for (int m = 0; m < 8; m++) begin
         lock_in <= seed[m];
         send(ref_word(3'(m), 4'h2, 12'h010));
         check_all();
         if (m != 3 && m != 4) begin
            apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
            chk(rd, {30'h0, exp_mux(), 1'b0}, "status mux");
         end
      end
      give_verdict();
   end
endmodule
